// ### hdl/tlw_pkg.sv
// Constants for the trigger-line watchdog routing block.
// Assumes a single 40 MHz clock and a byte-offset register port.
// Summary of operation
// - Expiry pulses selected lines for 200 ns
// - Nine line bits; bit 8 is star
// - Selected line edge expires the watchdog
// - Config bit 0 chooses sync or async
// - Sync mode samples lines every 100 ns
// - Async mode catches very short pulses
// - Async detection after reset
// - Config bit 2 enables rising edges
// - Config bit 1 enables falling edges
// - Timeout counted in 100 ns units
package tlw_pkg;
	// Clock and documented times
	localparam int CLK_PERIOD_PS = 25000;
	localparam int PULSE_TIME_NS = 200;
	localparam int SAMPLE_TIME_NS = 100;
	// Exact pulse length, floored
	localparam int PULSE_CYCLES = (PULSE_TIME_NS * 1000) / CLK_PERIOD_PS;
	// Least hold time, rounded up
	localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Bus and line geometry
	localparam int LINE_COUNT = 9;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	// Register offsets
	localparam logic [7:0] OFS_EXPIRY_SEL = 8'h10;
	localparam logic [7:0] OFS_WDT_SEL = 8'h12;
	localparam logic [7:0] OFS_EDGE_CFG = 8'h16;
	// Edge configuration fields
	localparam int CFG_W = 3;
	localparam int CFG_SYNC_BIT = 0;
	localparam int CFG_FALL_BIT = 1;
	localparam int CFG_RISE_BIT = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;
endpackage

// ### hdl/tlw_top.sv
// Trigger-line routing and edge detection around the watchdog.
// Assumes line inputs and register strobes are synchronous to clk.
`timescale 1ns/1ps
module tlw_top #(
	parameter int LINES = tlw_pkg::LINE_COUNT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [tlw_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [tlw_pkg::DATA_W-1:0] reg_wdata,
	output logic [tlw_pkg::DATA_W-1:0] reg_rdata,
	// Watchdog counter side
	input wire logic wdt_expire,
	output logic wdt_trig_expire,
	output logic tick_100ns,
	// Trigger lines, wired-OR style, driven high or released
	input wire logic [LINES-1:0] trig_in,
	output logic [LINES-1:0] trig_out,
	output logic [LINES-1:0] trig_oe
);

	// Refuse widths the 16-bit registers cannot hold
	if (LINES < 1 || LINES > tlw_pkg::DATA_W) begin : g_bad_lines
		$error("LINES must be between 1 and 16");
	end

	// Counter widths sized to hold the documented counts
	localparam int PCW = $clog2(tlw_pkg::PULSE_CYCLES + 1);
	localparam int TCW = $clog2(tlw_pkg::SAMPLE_CYCLES + 1);
	localparam logic [PCW-1:0] PULSE_LOAD = PCW'(tlw_pkg::PULSE_CYCLES);
	localparam logic [TCW-1:0] TICK_LAST = TCW'(tlw_pkg::SAMPLE_CYCLES - 1);

	// Configuration registers
	logic [LINES-1:0] expiry_sel_q; // Lines pulsed on expiry
	logic [LINES-1:0] wdt_sel_q; // Lines allowed to expire the watchdog
	logic [tlw_pkg::CFG_W-1:0] cfg_q; // Rise, fall, sync mode
	logic [tlw_pkg::DATA_W-1:0] rdata_q; // Read answer
	// Timing state
	logic [TCW-1:0] tick_cnt_q; // 100 ns divider
	logic tick_q; // One-cycle 100 ns enable
	logic [PCW-1:0] pulse_cnt_q; // Remaining pulse cycles
	logic [PCW-1:0] pulse_cnt_d;
	logic pulse_on_q; // Pulse in progress
	logic [LINES-1:0] oe_q; // Line drive enables
	// Edge detection state
	logic [LINES-1:0] line_q; // Registered line levels
	logic [LINES-1:0] line_prev_q; // Previous cycle levels
	logic [LINES-1:0] samp_q; // Level at last 100 ns sample
	logic [LINES-1:0] rise_hit; // Rising edges this cycle
	logic [LINES-1:0] fall_hit; // Falling edges this cycle
	logic trig_exp_q; // Expiry request to the watchdog
	logic cfg_written_q; // Helper: config ever written

	// Address decode on the full byte offset, so no aliases
	// Strobes are one-cycle pulses, so no edge detect is needed
	wire wr_expiry = reg_wr && (reg_addr == tlw_pkg::OFS_EXPIRY_SEL);
	wire wr_wdt = reg_wr && (reg_addr == tlw_pkg::OFS_WDT_SEL);
	wire wr_cfg = reg_wr && (reg_addr == tlw_pkg::OFS_EDGE_CFG);
	wire mode_sync = cfg_q[tlw_pkg::CFG_SYNC_BIT];
	wire sense_rise = cfg_q[tlw_pkg::CFG_RISE_BIT];
	wire sense_fall = cfg_q[tlw_pkg::CFG_FALL_BIT];

	// Register writes; upper bits are not stored, so they read as zero
	// Software must still write zeros there; nothing here checks it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			expiry_sel_q <= '0;
			wdt_sel_q <= '0;
			cfg_q <= tlw_pkg::CFG_RESET;
			cfg_written_q <= 1'b0;
		end else begin
			if (wr_expiry) begin
				expiry_sel_q <= reg_wdata[LINES-1:0];
			end
			if (wr_wdt) begin
				wdt_sel_q <= reg_wdata[LINES-1:0];
			end
			if (wr_cfg) begin
				cfg_q <= reg_wdata[tlw_pkg::CFG_W-1:0];
				cfg_written_q <= 1'b1;
			end
		end
	end

	// Read mux; unmapped offsets answer zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			rdata_q <= '0;
			case (reg_addr)
				tlw_pkg::OFS_EXPIRY_SEL: rdata_q[LINES-1:0] <= expiry_sel_q;
				tlw_pkg::OFS_WDT_SEL: rdata_q[LINES-1:0] <= wdt_sel_q;
				tlw_pkg::OFS_EDGE_CFG: rdata_q[tlw_pkg::CFG_W-1:0] <= cfg_q;
				default: rdata_q <= '0;
			endcase
		end
	end

	// 100 ns enable; also the timeout unit for the watchdog counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// Pulse length; a new expiry restarts the full length
	// Trade-off: a restart stretches the pulse rather than leaving a gap
	always_comb begin
		if (wdt_expire) begin
			pulse_cnt_d = PULSE_LOAD;
		end else if (pulse_cnt_q != '0) begin
			pulse_cnt_d = pulse_cnt_q - 1'b1;
		end else begin
			pulse_cnt_d = '0;
		end
	end

	// Pulse drive; only selected lines, released otherwise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_cnt_q <= '0;
			pulse_on_q <= 1'b0;
			oe_q <= '0;
		end else begin
			pulse_cnt_q <= pulse_cnt_d;
			pulse_on_q <= (pulse_cnt_d != '0);
			oe_q <= (pulse_cnt_d != '0) ? expiry_sel_q : '0;
		end
	end

	// Line sampling; async compares every clock, sync every tick
	// The sample runs in both modes, so a mode switch needs no warm-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= '0;
			line_prev_q <= '0;
			samp_q <= '0;
		end else begin
			line_q <= trig_in;
			line_prev_q <= line_q;
			if (tick_q) begin
				samp_q <= line_q;
			end
		end
	end

	// Per-line edge terms; same settings for every line
	// Limitation: async mode cannot see pulses shorter than one clock
	for (genvar i = 0; i < LINES; i++) begin : g_edge
		always_comb begin
			if (mode_sync) begin
				// Only levels held across a 100 ns sample count
				rise_hit[i] = tick_q && line_q[i] && !samp_q[i];
				fall_hit[i] = tick_q && !line_q[i] && samp_q[i];
			end else begin
				// Inputs arrive clock-synchronous, so the shortest caught pulse is one clock
				rise_hit[i] = line_q[i] && !line_prev_q[i];
				fall_hit[i] = !line_q[i] && line_prev_q[i];
			end
		end
	end

	// Expiry request from any enabled line with an enabled edge
	// Registered, so the watchdog sees a clean request; edges in back-to-back cycles give a request of several cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_exp_q <= 1'b0;
		end else begin
			trig_exp_q <= |(wdt_sel_q & ((rise_hit & {LINES{sense_rise}}) |
				(fall_hit & {LINES{sense_fall}})));
		end
	end

	// Outputs straight from flops
	// Level and enable share one flop: a driven line goes high
	assign reg_rdata = rdata_q;
	assign wdt_trig_expire = trig_exp_q;
	assign tick_100ns = tick_q;
	assign trig_oe = oe_q;
	assign trig_out = oe_q;

	// Checks on the expiry pulse
	// Full 200 ns after each expiry, a restart included
	AST_PULSE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		wdt_expire |=> pulse_on_q [*8])
		else $error("expiry pulse shorter than 200 ns");
	// Released once 200 ns pass with no new expiry
	AST_PULSE_END: assert property (@(posedge clk) disable iff (!rst_n)
		(wdt_expire ##1 (!wdt_expire) [*8]) |=> !pulse_on_q && (oe_q == '0))
		else $error("expiry pulse longer than 200 ns");
	// Drive starts on the selected lines right after expiry
	AST_PULSE_START: assert property (@(posedge clk) disable iff (!rst_n)
		wdt_expire |=> (oe_q == $past(expiry_sel_q)))
		else $error("expiry pulse not on the selected lines");
	// Nothing driven outside a pulse
	AST_IDLE_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
		!pulse_on_q |-> (oe_q == '0))
		else $error("line driven outside a pulse");
	// A driven line goes high, so level and enable agree
	AST_LINE_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
		trig_out == trig_oe)
		else $error("line level differs from its enable");
	// Never drive a line that was not selected
	AST_SEL_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
		##1 ((oe_q & ~$past(expiry_sel_q)) == '0))
		else $error("unselected line driven");
	// Checks on the register port
	// Select writes land whole at the strobe edge
	AST_WR_EXPIRY_SEL: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_addr == tlw_pkg::OFS_EXPIRY_SEL)
		|=> (expiry_sel_q == LINES'($past(reg_wdata))))
		else $error("expiry select write lost");
	AST_WR_WDT_SEL: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_addr == tlw_pkg::OFS_WDT_SEL)
		|=> (wdt_sel_q == LINES'($past(reg_wdata))))
		else $error("watchdog select write lost");
	// Only the three configuration bits are kept
	AST_WR_CFG: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_addr == tlw_pkg::OFS_EDGE_CFG)
		|=> (cfg_q == tlw_pkg::CFG_W'($past(reg_wdata))))
		else $error("edge config write lost");
	// Bits above the line count are never stored
	AST_RDATA_UPPER: assert property (@(posedge clk) disable iff (!rst_n)
		((reg_rdata >> LINES) == '0))
		else $error("unstored bits read as one");
	// Read answer stands until the next read
	AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read answer changed without a read");
	// Unmapped offsets answer zero
	AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr != tlw_pkg::OFS_EXPIRY_SEL && reg_addr != tlw_pkg::OFS_WDT_SEL
		&& reg_addr != tlw_pkg::OFS_EDGE_CFG) |=> (reg_rdata == '0))
		else $error("unmapped read not zero");
	// Config readback carries the stored bits
	AST_READBACK: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == tlw_pkg::OFS_EDGE_CFG)
		|=> reg_rdata == {{(tlw_pkg::DATA_W-tlw_pkg::CFG_W){1'b0}}, $past(cfg_q)})
		else $error("config readback wrong");
	// Checks on the time base
	// One enable every 100 ns, also the timeout unit
	AST_TICK_RATE: assert property (@(posedge clk) disable iff (!rst_n)
		tick_q |=> (!tick_q) [*3] ##1 tick_q)
		else $error("100 ns enable period wrong");
	// Checks on edge detection
	// Async until software writes the mode bit
	AST_ASYNC_AT_RESET: assert property (@(posedge clk) disable iff (!rst_n)
		!cfg_written_q |-> !mode_sync)
		else $error("sync mode before software chose it");
	// Async: a one-clock change on any selected line counts
	AST_ASYNC_RISE: assert property (@(posedge clk) disable iff (!rst_n)
		(!mode_sync && sense_rise && ((wdt_sel_q & line_q & ~line_prev_q) != '0))
		|=> wdt_trig_expire)
		else $error("async rising edge missed");
	AST_FALL_SENSE: assert property (@(posedge clk) disable iff (!rst_n)
		(!mode_sync && sense_fall && ((wdt_sel_q & ~line_q & line_prev_q) != '0))
		|=> wdt_trig_expire)
		else $error("falling edge missed");
	// Async: no change, no expiry
	AST_ASYNC_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		(!mode_sync && (line_q == line_prev_q)) |=> !wdt_trig_expire)
		else $error("async expiry with no line change");
	// Sync: a new level at a sample counts
	AST_SYNC_RISE: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_sync && tick_q && sense_rise && ((wdt_sel_q & line_q & ~samp_q) != '0))
		|=> wdt_trig_expire)
		else $error("sync rising edge missed");
	// Sync: same level at a sample, no expiry
	AST_SYNC_HELD: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_sync && tick_q && (line_q == samp_q)) |=> !wdt_trig_expire)
		else $error("sync expiry with no level change");
	// Sync: nothing between samples
	AST_SYNC_TICK: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_sync && !tick_q) |=> !wdt_trig_expire)
		else $error("sync expiry off the 100 ns sample");
	// Unselected lines and disabled edges stay silent
	AST_NO_SEL: assert property (@(posedge clk) disable iff (!rst_n)
		(wdt_sel_q == '0) |=> !wdt_trig_expire)
		else $error("expiry from unselected line");
	AST_NO_SENSE: assert property (@(posedge clk) disable iff (!rst_n)
		(!sense_rise && !sense_fall) |=> !wdt_trig_expire)
		else $error("expiry with no edge enabled");
	// Main scenarios
	COV_PULSE: cover property (@(posedge clk) disable iff (!rst_n)
		wdt_expire ##1 (oe_q != '0));
	COV_PULSE_RESTART: cover property (@(posedge clk) disable iff (!rst_n)
		pulse_on_q && wdt_expire);
	COV_SYNC_TRIG: cover property (@(posedge clk) disable iff (!rst_n)
		mode_sync ##1 wdt_trig_expire);
	COV_ASYNC_FALL: cover property (@(posedge clk) disable iff (!rst_n)
		(!mode_sync && sense_fall && !sense_rise) ##1 wdt_trig_expire);
	COV_BOTH_EDGES: cover property (@(posedge clk) disable iff (!rst_n)
		(!mode_sync && sense_rise && sense_fall) ##1 wdt_trig_expire ##1 wdt_trig_expire);

endmodule

// ### dv/tlw_line_partner.sv
// Model of another module sharing the trigger lines.
// Assumes a pull-down on each line; the bench strobes go.
`timescale 1ns/1ps
module tlw_line_partner (
	// Clock
	input wire logic clk,
	// Pulse request
	input wire logic go,
	input wire logic [3:0] idx,
	input wire logic [7:0] len,
	// Drive onto the lines
	output logic [8:0] drv
);
	logic [7:0] left_q = 8'h00; // Cycles still to drive
	logic [3:0] line_q = 4'h0; // Line in use
	initial drv = 9'h000;
	// One line at a time, never shared with our own routes
	always @(posedge clk) begin
		if (go) begin
			left_q = len;
			line_q = idx;
		end else if (left_q != 8'h00) begin
			left_q = left_q - 8'h01;
		end
		// Released line falls to the pull-down level
		#1 drv = (left_q != 8'h00) ? (9'h001 << line_q) : 9'h000;
	end
endmodule

// ### dv/trigger_line_watchdog_routing_test.sv
// Self-checking bench for the trigger-line watchdog block.
// Assumes tlw_top and the line partner on one 40 MHz clock.
`timescale 1ns/1ps
module trigger_line_watchdog_routing_test;
	logic clk = 1'b0; // 40 MHz
	logic rst_n = 1'b0; // Reset, active low
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata, r;
	logic wdt_expire = 1'b0;
	logic wdt_trig_expire, tick_100ns, rd_d = 1'b0;
	logic [8:0] trig_in, trig_out, trig_oe, drv, pv, po;
	logic [31:0] pn; // Pulse note being checked
	logic go = 1'b0;
	logic [3:0] idx = 4'h0;
	logic [7:0] len = 8'h00;
	int failures = 0, total_checks = 0, cyc = 0, run = 0, tk = 0, i, lo, hi;
	logic [15:0] rd_q[$]; // Expected read words
	logic [31:0] pl_q[$]; // Expected pulse length and lines
	int lo_q[$], hi_q[$]; // Expected trigger cycle window
	tlw_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.wdt_expire(wdt_expire), .wdt_trig_expire(wdt_trig_expire),
		.tick_100ns(tick_100ns), .trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe));
	tlw_line_partner u_far (.clk(clk), .go(go), .idx(idx), .len(len), .drv(drv));
	// Line level: our drive or the far side's
	assign trig_in = drv | (trig_oe & trig_out);
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rd_d <= reg_rd;
	end
	// Watcher: settled outputs against the oldest note
	always @(negedge clk) begin
		if (rd_d) check("rdata", reg_rdata, rd_q.pop_front());
		if (tick_100ns) tk++;
		if (wdt_trig_expire !== 1'b0 && lo_q.size() == 0) check("trig_extra", 1, 0);
		else if (wdt_trig_expire !== 1'b0) begin
			lo = lo_q.pop_front();
			hi = hi_q.pop_front();
			check("trig_at", 32'(cyc >= lo && cyc <= hi), 1);
		end
		if (trig_oe !== 9'h000) begin
			if (run == 0) begin
				pv = trig_oe;
				po = 9'h000;
			end
			po = po | trig_out;
			run++;
		end else if (run != 0) begin
			pn = pl_q.pop_front();
			check("pulse", {run[15:0], 7'h00, pv}, pn);
			check("trig_out", 32'(po), 32'(pn[8:0]));
			run = 0;
		end
	end
	task check(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s exp=%h seen=%h", nm, exp, seen);
		end
	endtask
	task results();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Bounded wait until every note is met
	task drain();
		int n;
		for (n = 0; n < 60 && rd_q.size() + pl_q.size() + lo_q.size() > 0; n++) @(posedge clk);
		if (n == 60) begin
			failures++;
			results();
		end
		repeat (8) @(posedge clk);
	endtask
	// One strobed cycle; a read notes d as the expected word
	task access(logic wr, logic [7:0] a, logic [15:0] d);
		@(posedge clk) #1;
		reg_addr = a;
		reg_wdata = d;
		if (wr) reg_wr = 1'b1;
		else begin
			rd_q.push_back(d);
			reg_rd = 1'b1;
		end
		@(posedge clk) #1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask
	// Expiry strobe; again > 1 restarts the pulse mid-way
	task expire(logic [8:0] sel, int again);
		access(1, 8'h10, {7'h00, sel});
		pl_q.push_back({16'(8 + again), 7'h00, sel});
		@(posedge clk) #1 wdt_expire = 1'b1;
		@(posedge clk) #1 wdt_expire = 1'b0;
		if (again > 1) begin
			repeat (again - 1) @(posedge clk);
			#1 wdt_expire = 1'b1;
			@(posedge clk) #1 wdt_expire = 1'b0;
		end
		drain();
	endtask
	task note(int at, logic sync);
		lo_q.push_back(at);
		hi_q.push_back(at + (sync ? 3 : 0));
	endtask
	// Far-side pulse, started in the same cycle as a time-base tick
	task edge_run(logic [3:0] ln, logic [7:0] n, logic [2:0] cfg, logic [8:0] sel);
		int c;
		access(1, 8'h12, {7'h00, sel});
		access(1, 8'h16, {13'h0000, cfg});
		for (c = 0; c < 40 && !tick_100ns; c++) @(negedge clk);
		if (c == 40) begin
			failures++;
			results();
		end
		repeat (4) @(posedge clk);
		#1 go = 1'b1;
		idx = ln;
		len = n;
		c = cyc;
		if (sel[ln] && (!cfg[0] || n > 8'h03)) begin
			if (cfg[2]) note(c + 3, cfg[0]);
			if (cfg[1]) note(c + 3 + n, cfg[0]);
		end
		@(posedge clk) #1 go = 1'b0;
		drain();
	endtask
	initial begin
		void'($urandom(66089));
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		access(0, 8'h10, 16'h0000);
		access(0, 8'h12, 16'h0000);
		access(0, 8'h16, 16'h0000);
		r = 16'($urandom) & 16'h01FF;
		access(1, 8'h10, r);
		access(0, 8'h10, r);
		access(1, 8'h14, 16'h01FF);
		access(0, 8'h14, 16'h0000);
		i = tk;
		repeat (40) @(posedge clk);
		check("ticks", 32'(tk - i), 32'h0000000A);
		expire(9'h100, 0);
		expire(r[8:0] | 9'h001, 3);
		for (i = 0; i < 8; i++) edge_run(4'($urandom % 9), 8'h08, i[2:0], 9'h1FF);
		edge_run(4'h8, 8'h01, 3'h6, 9'h100);
		edge_run(4'h8, 8'h01, 3'h7, 9'h100);
		edge_run(4'h2, 8'h08, 3'h6, 9'h1FB);
		results();
	end
endmodule
